// ==== rtl/etc_capture.sv ====
// etc_capture: one input capture channel with noise filter and read lock
`timescale 1ns/10ps
module etc_capture (
  input  wire logic        clk,
  input  wire logic        srst,
  input  wire logic        clk_en,
  etc_time_if.cap          tb,
  input  wire logic        cap_pin,
  input  wire logic        enable,
  input  wire logic [1:0]  edge_mode,
  input  wire logic        rd_hi,
  output logic      [15:0] latest,
  output logic      [15:0] previous,
  output logic             irq
);
  // ==========================================================
  // state
  typedef struct packed {
    logic        s1;     // sync stage 1
    logic        s2;     // sync stage 2
    logic        s3;     // sync stage 3
    logic [1:0]  smp_div; // fc/4 sample phase
    logic        smp;    // last sample
    logic        lvl;    // filtered level
    logic        locked; // capture blocked until read
    logic [15:0] latest;
    logic [15:0] previous;
    logic        irq;
  } etc_cap_t;

  etc_cap_t st_ff;
  etc_cap_t nxt_st;
  logic     edge_ok;     // qualified edge this cycle

  assign latest   = st_ff.latest;
  assign previous = st_ff.previous;
  assign irq      = st_ff.irq;

  // ==========================================================
  // next state
  always_comb begin
    nxt_st         = st_ff;
    nxt_st.s1      = cap_pin;
    nxt_st.s2      = st_ff.s1;
    nxt_st.s3      = st_ff.s2;
    nxt_st.irq     = 1'b0;
    nxt_st.smp_div = st_ff.smp_div + 2'h1;
    edge_ok        = 1'b0;
    // sample at fc/4; two equal samples pass the noise filter
    if (st_ff.smp_div == etc_pkg::SMP_LAST && st_ff.s2 == st_ff.s3) begin
      nxt_st.smp = st_ff.s3;
      if (st_ff.s3 == st_ff.smp && st_ff.s3 != st_ff.lvl) begin
        nxt_st.lvl = st_ff.s3;
        edge_ok    = etc_pkg::edge_hit(edge_mode, st_ff.s3);
      end
    end
    if (rd_hi) begin
      nxt_st.locked = 1'b0;
    end
    // a read in the same cycle frees the channel for the new edge
    if (edge_ok && enable && (!st_ff.locked || rd_hi)) begin
      nxt_st.previous = st_ff.latest;
      nxt_st.latest   = tb.count;
      nxt_st.irq      = 1'b1;
      nxt_st.locked   = 1'b1;
    end
  end

  // ==========================================================
  // registers
  always_ff @(posedge clk) begin
    if (srst) begin
      st_ff <= '0;
    end else if (clk_en) begin
      st_ff <= nxt_st;
    end
  end
endmodule : etc_capture

// ==== rtl/etc_pkg.sv ====
// etc_pkg: constants, field layouts and helper functions of the extended timer
package etc_pkg;
  // ==========================================================
  // counter
  localparam int          CNT_W     = 16;
  typedef logic [CNT_W-1:0] etc_word_t;             // counter-width word
  localparam etc_word_t   CNT_MAX   = 16'hffff;      // all-ones count
  localparam etc_word_t   CNT_RST   = 16'h0000;      // reset count
  localparam logic [7:0]  BYTE_RST  = 8'h00;         // reset of byte registers
  // ==========================================================
  // timer control register layout
  localparam int          RUN_BIT   = 7;             // count run bit
  localparam int          EDGE_BIT  = 3;             // event edge: 1 = falling
  localparam int          SRC_LSB   = 0;             // source clock select field
  localparam int          SRC_W     = 3;
  localparam logic [2:0]  SRC_EVENT = 3'h7;          // event counter mode
  localparam logic [2:0]  SRC_TOP   = 3'h5;          // last internal code
  // ==========================================================
  // channel mode register layout
  localparam int          ACT_LSB   = 0;             // compare action field
  localparam int          IC0_LSB   = 4;             // capture 0 edge field
  localparam int          IC1_LSB   = 6;             // capture 1 edge field
  // channel enable register layout
  localparam int          EN_IC0    = 4;
  localparam int          EN_IC1    = 5;
  localparam int          EN_OC0    = 6;
  // ==========================================================
  // encodings
  localparam logic [1:0]  ACT_NOP   = 2'h0;          // interrupt only
  localparam logic [1:0]  ACT_HIGH  = 2'h1;
  localparam logic [1:0]  ACT_LOW   = 2'h2;
  localparam logic [1:0]  ACT_TOG   = 2'h3;
  localparam logic [1:0]  EDGE_RISE = 2'h0;
  localparam logic [1:0]  EDGE_FALL = 2'h1;
  localparam logic [1:0]  EDGE_BOTH = 2'h2;
  // ==========================================================
  // timing
  localparam int          DIV_W     = 7;             // prescaler width
  localparam logic [6:0]  DIV_FULL  = 7'h7f;
  localparam logic [2:0]  MC_WAIT   = 3'h4;          // one machine cycle = 4 clk
  localparam logic [1:0]  SMP_LAST  = 2'h3;          // capture sample every 4 clk

  // does a new filtered level form an edge of the selected kind
  function automatic logic edge_hit(logic [1:0] mode, logic new_lvl);
    case (mode)
      EDGE_RISE: edge_hit = new_lvl;
      EDGE_FALL: edge_hit = !new_lvl;
      EDGE_BOTH: edge_hit = 1'b1;
      default:   edge_hit = 1'b0;
    endcase
  endfunction : edge_hit
endpackage : etc_pkg

// ==== rtl/etc_prescaler.sv ====
// etc_prescaler: dedicated prescaler and event pin edge counter source
`timescale 1ns/10ps
module etc_prescaler (
  input  wire logic clk,
  input  wire logic srst,
  input  wire logic clk_en,
  etc_time_if.prs   tb,
  input  wire logic event_pin
);
  // ==========================================================
  // state
  typedef struct packed {
    logic [6:0] div;    // free divider
    logic       s1;     // event sync stage 1
    logic       s2;     // event sync stage 2
    logic       s3;     // event sync stage 3
    logic       lvl;    // accepted event level
    logic       tick;   // registered count tick
  } etc_prs_t;

  etc_prs_t st_ff;
  etc_prs_t nxt_st;
  logic     adv;        // divider advances this cycle
  logic [6:0] mask;     // low divider bits of the selected ratio

  assign tb.cnt_tick = st_ff.tick;

  // ==========================================================
  // next state
  always_comb begin
    nxt_st    = st_ff;
    nxt_st.s1 = event_pin;
    nxt_st.s2 = st_ff.s1;
    nxt_st.s3 = st_ff.s2;
    nxt_st.tick = 1'b0;
    adv  = tb.slow ? tb.fs_tick : 1'b1;                    // fs or fc based
    mask = etc_pkg::DIV_FULL >> (etc_pkg::SRC_TOP - tb.src_sel);
    if (adv) begin
      nxt_st.div = st_ff.div + 7'h01;
    end
    if (tb.src_sel == etc_pkg::SRC_EVENT) begin
      // event counter mode: stable filtered edge
      if (st_ff.s2 == st_ff.s3 && st_ff.s3 != st_ff.lvl) begin
        nxt_st.lvl  = st_ff.s3;
        nxt_st.tick = tb.run && etc_pkg::edge_hit({1'b0, tb.edge_fall}, st_ff.s3);
      end
    end else if (tb.src_sel <= etc_pkg::SRC_TOP) begin
      // internal clock fc/2^(sel+2), or fs/2^(sel+2) when slow mode steps the divider on fs_tick
      nxt_st.tick = tb.run && adv && ((st_ff.div & mask) == mask);
    end
  end

  // ==========================================================
  // registers
  always_ff @(posedge clk) begin
    if (srst) begin
      st_ff <= '0;
    end else if (clk_en) begin
      st_ff <= nxt_st;
    end
  end
endmodule : etc_prescaler

// ==== rtl/etc_time_if.sv ====
// etc_time_if: time base shared by control, prescaler and capture channels
`timescale 1ns/10ps
interface etc_time_if;
  logic [15:0] count;      // current counter value
  logic        cnt_tick;   // one-cycle count advance
  logic [2:0]  src_sel;    // source clock select
  logic        edge_fall;  // event counts falling edges
  logic        run;        // count run bit
  logic        slow;       // slow clock in use
  logic        fs_tick;    // one pulse per slow clock period

  modport ctl (output count, src_sel, edge_fall, run, slow, fs_tick, input cnt_tick);
  modport prs (input src_sel, edge_fall, run, slow, fs_tick, output cnt_tick);
  modport cap (input count);
endinterface : etc_time_if

// ==== rtl/etc_timer.sv ====
// etc_timer: 16-bit extended timer-counter with two captures and one compare
//
// Contract
// - internal prescaler ticks advance the counter
// - overflow interrupt at all ones, keep counting
// - source select 111 means event counter
// - event mode counts chosen pin edge
// - preload low then high; high loads
// - one machine cycle wait after high write
// - zero clears; ones minus n gives interrupt
// - run bit seven starts and stops counting
// - first edge latches count, raises interrupt
// - capture locked until latest read, low first
// - later edges shift latest into previous
// - filter rejects pulses under six clocks
// - sample at quarter clock, bounded latency
// - capture edge rising, falling or both
// - overflow never disturbs capture
// - compare sets, clears, toggles or holds
// - match applies action, then interrupt
// - compare low first; high arms next match
// - action code 11 toggles the output
`timescale 1ns/10ps
module etc_timer (
  input  wire logic             clk,
  input  wire logic             srst,
  input  wire logic             clk_en,
  input  wire logic             slow_mode,
  input  wire logic             fs_tick,
  input  wire logic [7:0]       wdata,
  input  wire logic             ctrl_wr,
  input  wire logic             preload_lo_wr,
  input  wire logic             preload_hi_wr,
  input  wire logic             compare_lo_wr,
  input  wire logic             compare_hi_wr,
  input  wire logic             mode_wr,
  input  wire logic             enable_wr,
  input  wire logic [1:0]       cap_rd_lo,
  input  wire logic [1:0]       cap_rd_hi,
  input  wire logic             event_pin,
  input  wire logic [1:0]       capture_pin,
  output logic      [15:0]      count_value,
  output logic      [1:0][15:0] latest_capture_register,
  output logic      [1:0][15:0] previous_capture_register,
  output logic                  count_run_bit,
  output logic                  compare_armed,
  output logic                  compare_output_0,
  output logic                  compare_output_0_oe_n,
  output logic                  overflow_interrupt,
  output logic      [1:0]       capture_interrupt,
  output logic                  compare_interrupt_0
);
  // ==========================================================
  // state of the control side
  typedef struct packed {
    logic [7:0]  ctrl;       // timer control register
    logic [7:0]  mode;       // channel mode register
    logic [7:0]  enable;     // channel enable register
    logic [7:0]  pre_lo;     // held low byte of preload
    logic [7:0]  cmp_lo;     // held low byte of compare
    logic [15:0] cmp;        // compare value register
    logic [15:0] cnt;        // the counter
    logic [2:0]  wait_cnt;   // machine cycle wait after preload
    logic        armed;      // compare may fire
    logic        oc;         // compare pin level
    logic        ovf_irq;    // overflow pulse
    logic        cmp_pend;   // compare action done, interrupt next
    logic        cmp_irq;    // compare pulse
  } etc_ctl_t;

  etc_ctl_t   st_ff;
  etc_ctl_t   nxt_st;
  etc_time_if tb ();         // shared time base
  logic       advance;       // counter steps this cycle
  logic [1:0] act;           // selected compare action
  logic [1:0] cap_en;        // capture enables per channel
  logic [1:0][1:0] cap_edge; // capture edge modes per channel

  // ==========================================================
  // field decoding
  // pick a two-bit field out of a byte
  function automatic logic [1:0] field2(logic [7:0] r, int lsb);
    field2 = r[lsb +: 2];
  endfunction : field2

  assign act         = field2(st_ff.mode, etc_pkg::ACT_LSB);
  assign cap_edge[0] = field2(st_ff.mode, etc_pkg::IC0_LSB);
  assign cap_edge[1] = field2(st_ff.mode, etc_pkg::IC1_LSB);
  assign cap_en[0]   = st_ff.enable[etc_pkg::EN_IC0];
  assign cap_en[1]   = st_ff.enable[etc_pkg::EN_IC1];

  // ==========================================================
  // time base drive
  assign tb.count     = st_ff.cnt;
  assign tb.src_sel   = st_ff.ctrl[etc_pkg::SRC_LSB +: etc_pkg::SRC_W];
  assign tb.edge_fall = st_ff.ctrl[etc_pkg::EDGE_BIT];
  assign tb.run       = st_ff.ctrl[etc_pkg::RUN_BIT];
  assign tb.slow      = slow_mode;
  assign tb.fs_tick   = fs_tick;

  // ==========================================================
  // outputs
  assign count_value           = st_ff.cnt;
  assign count_run_bit         = st_ff.ctrl[etc_pkg::RUN_BIT];
  assign compare_armed         = st_ff.armed;
  assign compare_output_0      = st_ff.oc;
  // pin driven only while the compare channel owns it
  assign compare_output_0_oe_n = !st_ff.enable[etc_pkg::EN_OC0];
  assign overflow_interrupt    = st_ff.ovf_irq;
  assign compare_interrupt_0   = st_ff.cmp_irq;

  // ==========================================================
  // next state
  always_comb begin
    nxt_st          = st_ff;
    nxt_st.ovf_irq  = 1'b0;
    nxt_st.cmp_irq  = st_ff.cmp_pend;                       // interrupt after action
    nxt_st.cmp_pend = 1'b0;
    advance         = 1'b0;

    // plain register writes
    if (ctrl_wr) begin
      nxt_st.ctrl = wdata;
    end
    if (mode_wr) begin
      nxt_st.mode = wdata;
    end
    if (enable_wr) begin
      nxt_st.enable = wdata;
    end
    if (preload_lo_wr) begin
      nxt_st.pre_lo = wdata;                                // held only
    end
    if (compare_lo_wr) begin
      nxt_st.cmp_lo = wdata;                                // held only
    end

    // counter: preload, wait, or count
    if (preload_hi_wr) begin
      nxt_st.cnt      = {wdata, st_ff.pre_lo};
      nxt_st.wait_cnt = etc_pkg::MC_WAIT;
    end else if (st_ff.wait_cnt != 3'h0) begin
      nxt_st.wait_cnt = st_ff.wait_cnt - 3'h1;
    end else if (tb.cnt_tick && st_ff.ctrl[etc_pkg::RUN_BIT]) begin
      advance    = 1'b1;
      nxt_st.cnt = st_ff.cnt + 16'h0001;                    // wraps past all ones
      if (nxt_st.cnt == etc_pkg::CNT_MAX) begin
        nxt_st.ovf_irq = 1'b1;
      end
    end

    // compare match: action on the pin, interrupt one cycle later
    if (st_ff.armed && advance && nxt_st.cnt == st_ff.cmp) begin
      nxt_st.armed    = 1'b0;
      nxt_st.cmp_pend = 1'b1;
      if (st_ff.enable[etc_pkg::EN_OC0]) begin
        case (act)
          etc_pkg::ACT_HIGH: nxt_st.oc = 1'b1;
          etc_pkg::ACT_LOW:  nxt_st.oc = 1'b0;
          etc_pkg::ACT_TOG:  nxt_st.oc = !st_ff.oc;
          default:           nxt_st.oc = st_ff.oc;           // no change
        endcase
      end
    end

    // rearm: high write or stopped timer; wins over a match
    if (compare_hi_wr) begin
      nxt_st.cmp   = {wdata, st_ff.cmp_lo};
      nxt_st.armed = 1'b1;
    end else if (!st_ff.ctrl[etc_pkg::RUN_BIT]) begin
      nxt_st.armed = 1'b1;
    end
  end

  // ==========================================================
  // registers
  always_ff @(posedge clk) begin
    if (srst) begin
      st_ff        <= '0;
      st_ff.cnt    <= etc_pkg::CNT_RST;
      st_ff.ctrl   <= etc_pkg::BYTE_RST;
      st_ff.armed  <= 1'b1;
    end else if (clk_en) begin
      st_ff <= nxt_st;
    end
  end

  // ==========================================================
  // prescaler and event source
  etc_prescaler u_prs (
    .clk       (clk),
    .srst      (srst),
    .clk_en    (clk_en),
    .tb        (tb.prs),
    .event_pin (event_pin)
  );

  // ==========================================================
  // capture channels
  for (genvar g = 0; g < 2; g++) begin : g_cap
    etc_capture u_cap (
      .clk       (clk),
      .srst      (srst),
      .clk_en    (clk_en),
      .tb        (tb.cap),
      .cap_pin   (capture_pin[g]),
      .enable    (cap_en[g]),
      .edge_mode (cap_edge[g]),
      .rd_hi     (cap_rd_hi[g]),
      .latest    (latest_capture_register[g]),
      .previous  (previous_capture_register[g]),
      .irq       (capture_interrupt[g])
    );
  end
endmodule : etc_timer

// ==== tb/etc_pin_model.sv ====
// etc_pin_model: external pulse sources on the event and capture pins
`timescale 1ns/10ps
module etc_pin_model (
  input  wire logic       clk,
  output logic            event_pin,
  output logic      [1:0] capture_pin
);
  initial begin
    event_pin   = 1'b0;
    capture_pin = 2'h0;
  end
  // event pulses: high held 12 clocks, low 13, slower than clock over eight
  task automatic ev_pulses(input int n);
    repeat (n) begin
      @(posedge clk) event_pin <= 1'b1;
      repeat (12) @(posedge clk);
      event_pin <= 1'b0;
      repeat (12) @(posedge clk);
    end
  endtask : ev_pulses
  // hold a capture level; long holds pass the noise filter, short ones probe it
  task automatic cap_set(input int ch, input logic lvl, input int w);
    @(posedge clk) capture_pin <= ch ? {lvl, capture_pin[0]} : {capture_pin[1], lvl};
    repeat (w) @(posedge clk);
  endtask : cap_set
endmodule : etc_pin_model

// ==== tb/etc_timer_assertions.sv ====
// etc_timer_assertions: port-level checks of the extended timer
`timescale 1ns/10ps
module etc_timer_assertions (
  input wire logic             clk,
  input wire logic             srst,
  input wire logic             clk_en,
  input wire logic [7:0]       wdata,
  input wire logic             ctrl_wr,
  input wire logic             preload_lo_wr,
  input wire logic             preload_hi_wr,
  input wire logic             compare_lo_wr,
  input wire logic             compare_hi_wr,
  input wire logic             mode_wr,
  input wire logic             enable_wr,
  input wire logic [1:0]       cap_rd_hi,
  input wire logic [15:0]      count_value,
  input wire logic [1:0][15:0] latest_capture_register,
  input wire logic [1:0][15:0] previous_capture_register,
  input wire logic             count_run_bit,
  input wire logic             compare_armed,
  input wire logic             compare_output_0,
  input wire logic             overflow_interrupt,
  input wire logic [1:0]       capture_interrupt,
  input wire logic             compare_interrupt_0
);
  // ==========================================
  // shadows of write-only registers and the capture 0 lock
  logic [7:0]  pl_lo_ff, cmp_lo_ff, mode_ff;
  logic [15:0] cmp_ff;
  logic        oc_en_ff, lock_ff;
  always_ff @(posedge clk) begin
    if (srst) begin
      {pl_lo_ff, cmp_lo_ff, mode_ff, cmp_ff, oc_en_ff, lock_ff} <= '0;
    end else if (clk_en) begin
      if (preload_lo_wr) pl_lo_ff <= wdata;
      if (compare_lo_wr) cmp_lo_ff <= wdata;
      if (compare_hi_wr) cmp_ff <= {wdata, cmp_lo_ff};
      if (mode_wr) mode_ff <= wdata;
      if (enable_wr) oc_en_ff <= wdata[etc_pkg::EN_OC0];
      if (capture_interrupt[0]) lock_ff <= 1'b1;
      else if (cap_rd_hi[0]) lock_ff <= 1'b0;
    end
  end
  // ==========================================
  // properties
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  sequence s_load_wait;
    ##1 $stable(count_value)[*3];
  endsequence
  sequence s_match;
    $fell(compare_armed);
  endsequence
  a_preload_load: assert property (
    preload_hi_wr && clk_en |=> count_value == {$past(wdata), $past(pl_lo_ff)})
    else $error("preload high write did not load the counter");
  a_preload_wait: assert property (
    preload_hi_wr && clk_en |=> s_load_wait)
    else $error("counter moved during the post-load wait");
  a_count_step: assert property (
    count_run_bit && clk_en && !preload_hi_wr |=>
      (count_value == $past(count_value)) || (count_value == $past(count_value) + 16'h1))
    else $error("counter did not step by one");
  a_stop_holds: assert property (
    !count_run_bit && !ctrl_wr && !preload_hi_wr |=> $stable(count_value))
    else $error("counter moved while stopped");
  a_ovf_top: assert property (
    count_value == etc_pkg::CNT_MAX && $past(count_value) == 16'hfffe |-> overflow_interrupt)
    else $error("no overflow pulse at the top count");
  a_ovf_value: assert property (
    overflow_interrupt |-> count_value == etc_pkg::CNT_MAX)
    else $error("overflow pulse off the top count");
  a_cap_shift: assert property (
    capture_interrupt[0] |-> latest_capture_register[0] == $past(count_value)
      && previous_capture_register[0] == $past(latest_capture_register[0]))
    else $error("capture values wrong");
  a_cap_locked: assert property (
    capture_interrupt[0] |-> !lock_ff)
    else $error("capture taken while locked");
  a_cmp_irq: assert property (
    s_match |=> compare_interrupt_0 && $past(count_value) == cmp_ff)
    else $error("compare interrupt missing after match");
  a_cmp_action: assert property (
    s_match and oc_en_ff |-> compare_output_0 ==
      (mode_ff[1:0] == etc_pkg::ACT_HIGH ? 1'b1 : mode_ff[1:0] == etc_pkg::ACT_LOW ? 1'b0 :
       mode_ff[1:0] == etc_pkg::ACT_TOG ? !$past(compare_output_0) : $past(compare_output_0)))
    else $error("compare output action wrong");
  a_cmp_rearm: assert property (
    compare_hi_wr && clk_en |=> compare_armed)
    else $error("compare high write did not arm");
endmodule : etc_timer_assertions

// ==== tb/tb_top.sv ====
// tb_top: self-checking bench for the extended timer
`timescale 1ns/10ps
`define CHK(a, e) begin samples_checked++; if ((a) !== (e)) begin err_total++; \
  $display("MISMATCH t=%0t got %h exp %h", $time, (a), (e)); end end
module tb_top;
  logic             clk, srst, clk_en, slow_mode, fs_tick;
  logic [7:0]       wdata;
  logic [6:0]       wr_s;
  logic             ctrl_wr, preload_lo_wr, preload_hi_wr, compare_lo_wr, compare_hi_wr;
  logic             mode_wr, enable_wr, event_pin, count_run_bit, compare_armed;
  logic [1:0]       cap_rd_lo, cap_rd_hi, capture_pin, capture_interrupt;
  logic [15:0]      count_value;
  logic [1:0][15:0] latest_capture_register, previous_capture_register;
  logic             compare_output_0, compare_output_0_oe_n;
  logic             overflow_interrupt, compare_interrupt_0;
  logic [3:0]       irq_v;
  int               err_total, samples_checked, fs_cnt;
  assign {enable_wr, mode_wr, compare_hi_wr, compare_lo_wr, preload_hi_wr, preload_lo_wr,
          ctrl_wr} = wr_s;
  assign irq_v = {compare_interrupt_0, capture_interrupt, overflow_interrupt};
  etc_timer     etc_timer_inst (.*);
  etc_pin_model etc_pin_model_inst (.*);
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  // slow clock tick once every 8 clocks
  always @(posedge clk) begin
    fs_cnt  <= (fs_cnt + 1) % 8;
    fs_tick <= (fs_cnt == 7);
  end
  // one register write: k = ctrl, pre lo, pre hi, cmp lo, cmp hi, mode, enable
  task automatic wr(input int k, input logic [7:0] d);
    @(posedge clk);
    wdata <= d;
    wr_s  <= 7'h01 << k;
    @(posedge clk);
    wr_s  <= 7'h00;
  endtask : wr
  task automatic ld(input int k, input logic [15:0] v);
    wr(k, v[7:0]);
    wr(k + 1, v[15:8]);
  endtask : ld
  task automatic rd(input int ch);
    @(posedge clk) cap_rd_lo <= 2'h1 << ch;
    @(posedge clk) cap_rd_lo <= 2'h0;
    cap_rd_hi <= 2'h1 << ch;
    @(posedge clk) cap_rd_hi <= 2'h0;
  endtask : rd
  // watch one interrupt for lim clocks; stop early once it is seen
  task automatic wait_irq(input int k, input int lim, input logic exp);
    logic seen;
    seen = 1'b0;
    for (int i = 0; i < lim && !seen; i++) begin
      @(negedge clk);
      seen = (irq_v[k] === 1'b1);
    end
    `CHK(seen, exp)
  endtask : wait_irq
  task automatic cap_edge(input int ch, input logic lvl, input logic exp);
    fork
      etc_pin_model_inst.cap_set(ch, lvl, 24);
      wait_irq(ch + 1, 24, exp);
    join
  endtask : cap_edge
  // clocks between two counter steps, after syncing to one step
  task automatic gap(output int n);
    logic [15:0] v;
    for (int p = 0; p < 2; p++) begin
      @(negedge clk) v = count_value;
      n = 1;
      while (count_value === v && n < 600) begin
        @(negedge clk);
        n++;
      end
    end
  endtask : gap
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : report_and_stop
  initial begin
    #200000;
    err_total++;
    $display("MISMATCH t=%0t watchdog expired", $time);
    report_and_stop();
  end
  // ==========================================
  // test sequence
  initial begin
    logic [15:0] v;
    int          n;
    logic [1:0]  acts [5] = '{etc_pkg::ACT_HIGH, etc_pkg::ACT_TOG, etc_pkg::ACT_TOG,
                              etc_pkg::ACT_NOP, etc_pkg::ACT_LOW};
    logic        outs [5] = '{1'b1, 1'b0, 1'b1, 1'b1, 1'b0};
    {srst, clk_en, slow_mode, wdata, wr_s} = {3'b110, 15'h0};
    {cap_rd_lo, cap_rd_hi, err_total, samples_checked} = '0;
    repeat (10) @(posedge clk);
    srst <= 1'b0;
    @(negedge clk) `CHK(count_run_bit, 1'b0)
    `CHK(compare_armed, 1'b1)
    ld(1, 16'h1234);
    wr(1, 8'h55);
    repeat (40) @(negedge clk);
    `CHK(count_value, 16'h1234)
    ld(1, 16'hfffd);
    wr(0, 8'h80);
    wait_irq(0, 100, 1'b1);
    `CHK(count_value, 16'hffff)
    repeat (4) @(negedge clk);
    `CHK(count_value, 16'h0000)
    $display("test preload done");
    for (int s = 0; s < 6; s++) begin
      wr(0, 8'h80 | 8'(s));
      gap(n);
      `CHK(n, 4 << s)
    end
    @(posedge clk) slow_mode <= 1'b1;
    wr(0, 8'h80);
    gap(n);
    `CHK(n, 32)
    // clock enable low freezes the running counter
    @(posedge clk) clk_en <= 1'b0;
    repeat (2) @(negedge clk) v = count_value;
    repeat (40) @(negedge clk);
    `CHK(count_value, v)
    @(posedge clk) clk_en <= 1'b1;
    @(posedge clk) slow_mode <= 1'b0;
    wr(0, 8'h86);
    // a tick already in flight may still land one cycle after the write
    repeat (2) @(negedge clk) v = count_value;
    repeat (200) @(negedge clk);
    `CHK(count_value, v)
    $display("test clock source done");
    for (int f = 0; f < 2; f++) begin
      wr(0, f ? 8'h0f : 8'h07);
      ld(1, 16'h0000);
      wr(0, f ? 8'h8f : 8'h87);
      etc_pin_model_inst.ev_pulses(5);
      repeat (10) @(negedge clk);
      `CHK(count_value, 16'h0005)
    end
    $display("test event done");
    wr(0, 8'h00);
    wr(6, 8'h70);
    wr(5, 8'h40);
    ld(1, 16'h1234);
    `CHK(compare_output_0_oe_n, 1'b0)
    cap_edge(0, 1'b1, 1'b1);
    ld(1, 16'h5678);
    cap_edge(0, 1'b0, 1'b0);
    cap_edge(0, 1'b1, 1'b0);
    `CHK(latest_capture_register[0], 16'h1234)
    rd(0);
    cap_edge(0, 1'b0, 1'b0);
    cap_edge(0, 1'b1, 1'b1);
    `CHK(latest_capture_register[0], 16'h5678)
    `CHK(previous_capture_register[0], 16'h1234)
    rd(0);
    cap_edge(1, 1'b1, 1'b0);
    cap_edge(1, 1'b0, 1'b1);
    `CHK(latest_capture_register[1], 16'h5678)
    rd(1);
    wr(5, 8'h80);
    for (int e = 1; e >= 0; e--) begin
      cap_edge(1, 1'(e), 1'b1);
      rd(1);
    end
    `CHK(previous_capture_register[1], 16'h5678)
    fork
      etc_pin_model_inst.cap_set(1, 1'b1, 2);
      wait_irq(2, 36, 1'b0);
    join_any
    etc_pin_model_inst.cap_set(1, 1'b0, 40);
    ld(1, 16'hfffd);
    wr(0, 8'h80);
    wait_irq(0, 100, 1'b1);
    cap_edge(0, 1'b0, 1'b0);
    cap_edge(0, 1'b1, 1'b1);
    $display("test capture done");
    for (int i = 0; i < 5; i++) begin
      wr(0, 8'h00);
      wr(5, {6'h00, acts[i]});
      ld(1, 16'h0100);
      ld(3, 16'h0108);
      wr(0, 8'h80);
      wait_irq(3, 100, 1'b1);
      `CHK(compare_output_0, outs[i])
    end
    $display("test compare done");
    report_and_stop();
  end
endmodule : tb_top
bind etc_timer etc_timer_assertions etc_timer_assertions_inst (.*);
